// [hw/foc_map.svh]
// constants of the flash option control / status block
// assumes a byte-addressed plain register port with 32-bit data
// Overview of operation
// - option programming allowed only when bit 9 set
// - error irq on program or protect fault
// - done irq on operation done flag
// - forced reload reloads options, pulses reset
// - hardware updates target address during operations
// - option register loads from option bytes
// - complement mismatch sets fault, forces 0xff
// - read guard level field, bits 2:1
// - watchdog, stop, standby bits 8..10
// - done flag set when operation ends
// - protect fault set on protected program
`ifndef FOC_MAP_SVH
`define FOC_MAP_SVH
`define FOC_OFS_STATUS 8'h0c
`define FOC_OFS_CTRL 8'h10
`define FOC_OFS_ADDR 8'h14
`define FOC_OFS_OPT 8'h1c
`define FOC_OFS_IRQ_STAT 8'h40
`define FOC_OFS_IRQ_MASK 8'h44
`define FOC_BIT_PGM_FAULT 2
`define FOC_BIT_PROT_FAULT 4
`define FOC_BIT_DONE 5
`define FOC_BIT_WR_ALLOW 9
`define FOC_BIT_FAULT_IE 10
`define FOC_BIT_DONE_IE 12
`define FOC_BIT_RELOAD 13
`define FOC_BIT_OPT_FAULT 0
`define FOC_RST_CTRL 32'h00000000
`define FOC_RST_ADDR 32'h00000000
`define FOC_RST_MASK 3'h7
`define FOC_BYTE_ERASED 8'hff
`define FOC_RELOAD_RST_CYC 4'h8
`endif

// [hw/foc_pkg.sv]
// types of the flash option control / status block
// assumes foc_map.svh for all numbers
package foc_pkg;
  // one option byte as stored with its complement
  typedef struct packed {
    logic [7:0] cmpl;
    logic [7:0] val;
  } foc_opt_pair_t;
  // events reported by the flash sequencer outside
  typedef struct packed {
    logic pgm_fault;
    logic prot_fault;
    logic done;
  } foc_evt_t;
  typedef enum logic [1:0] {
    FOC_IDLE,
    FOC_LOAD,
    FOC_RESET
  } foc_state_t;
endpackage

// [hw/foc_opt_check.sv]
// checks one option byte against its complement
// assumes the pair is stable while load is sampled
`timescale 1ns/1ps
`default_nettype none
`include "foc_map.svh"
module foc_opt_check
  import foc_pkg::*;
(
  // stored pair
  input wire foc_opt_pair_t pair,
  // checked byte and mismatch flag
  output logic [7:0] byte_out,
  output logic bad
);
  always_comb begin
    bad = (pair.val != ~pair.cmpl);
    byte_out = bad ? `FOC_BYTE_ERASED : pair.val;
  end
endmodule
`default_nettype wire

// [hw/foc_top.sv]
// upper control bits, target address and option status of the flash
// controller; assumes a plain register port and an outside sequencer
`timescale 1ns/1ps
`default_nettype none
`include "foc_map.svh"
module foc_top
  import foc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // sequencer side
  input wire foc_evt_t evt,
  input wire logic op_busy,
  input wire logic [31:0] op_addr,
  input wire logic opt_pgm_req,
  output logic opt_pgm_go,
  // option byte storage: read guard, user, user data 0, data 1
  input wire foc_opt_pair_t opt_guard,
  input wire foc_opt_pair_t opt_user,
  input wire foc_opt_pair_t opt_user_byte_low,
  input wire foc_opt_pair_t opt_user_byte_high,
  // system
  output logic sys_reset_req,
  output logic irq
);
  // ------------------------------------------------------------
  // option byte check
  // ------------------------------------------------------------
  logic [7:0] chk_byte [4];
  logic [3:0] chk_bad;
  foc_opt_check u_chk0 (.pair(opt_guard), .byte_out(chk_byte[0]),
    .bad(chk_bad[0]));
  foc_opt_check u_chk1 (.pair(opt_user), .byte_out(chk_byte[1]),
    .bad(chk_bad[1]));
  foc_opt_check u_chk2 (.pair(opt_user_byte_low), .byte_out(chk_byte[2]),
    .bad(chk_bad[2]));
  foc_opt_check u_chk3 (.pair(opt_user_byte_high), .byte_out(chk_byte[3]),
    .bad(chk_bad[3]));

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  foc_state_t st_r, st_nxt;
  logic [3:0] rcnt_r, rcnt_nxt;
  logic [31:0] opt_r, opt_nxt;
  logic [31:0] taddr_r, taddr_nxt;
  logic wr_allow_r, wr_allow_nxt;
  logic fault_ie_r, fault_ie_nxt;
  logic done_ie_r, done_ie_nxt;
  logic [2:0] flag_r, flag_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic [31:0] rdata_nxt;
  logic irq_nxt, go_nxt, sysrst_nxt;
  logic [1:0] guard_lvl;

  // mask register has the flag layout in its low three bits
  always_comb begin
    logic [2:0] w1c;
    logic [2:0] ev;
    w1c = 3'h0;
    ev = {evt.done, evt.prot_fault, evt.pgm_fault};
    st_nxt = st_r;
    rcnt_nxt = rcnt_r;
    opt_nxt = opt_r;
    taddr_nxt = taddr_r;
    wr_allow_nxt = wr_allow_r;
    fault_ie_nxt = fault_ie_r;
    done_ie_nxt = done_ie_r;
    mask_nxt = mask_r;
    sysrst_nxt = 1'b0;
    if (wr) begin
      unique case (addr)
        `FOC_OFS_CTRL: begin
          wr_allow_nxt = wdata[`FOC_BIT_WR_ALLOW];
          fault_ie_nxt = wdata[`FOC_BIT_FAULT_IE];
          done_ie_nxt = wdata[`FOC_BIT_DONE_IE];
          if (wdata[`FOC_BIT_RELOAD])
            st_nxt = FOC_LOAD;
        end
        `FOC_OFS_ADDR: taddr_nxt = wdata;
        `FOC_OFS_STATUS, `FOC_OFS_IRQ_STAT: w1c = {
          wdata[`FOC_BIT_DONE], wdata[`FOC_BIT_PROT_FAULT],
          wdata[`FOC_BIT_PGM_FAULT]};
        `FOC_OFS_IRQ_MASK: mask_nxt = wdata[2:0];
        default: ;
      endcase
    end
    // hardware tracks address
    // busy wins over a software write in the same cycle
    if (op_busy)
      taddr_nxt = op_addr;
    flag_nxt = (flag_r & ~w1c) | ev;
    unique case (st_r)
      FOC_IDLE: ;
      FOC_LOAD: begin
        // load options
        // field bits held by no option byte read as zero
        opt_nxt = {chk_byte[3], chk_byte[2], 1'b0, chk_byte[1][6:4],
          1'b0, chk_byte[1][2:0], 5'h00, guard_lvl,
          |chk_bad};
        rcnt_nxt = `FOC_RELOAD_RST_CYC;
        st_nxt = FOC_RESET;
      end
      FOC_RESET: begin
        sysrst_nxt = 1'b1;
        rcnt_nxt = rcnt_r - 4'h1;
        if (rcnt_r == 4'h1) begin
          // enables come back cleared, as after power-up
          st_nxt = FOC_IDLE;
          wr_allow_nxt = 1'b0;
          fault_ie_nxt = 1'b0;
          done_ie_nxt = 1'b0;
        end
      end
      default: st_nxt = FOC_IDLE;
    endcase
  end

  // guard level: 00 lvl0, 01 lvl1, 1x lvl2
  // a broken guard pair reads as the strictest level
  always_comb begin
    if (chk_bad[0])
      guard_lvl = 2'h2;
    else if (chk_byte[0] == 8'haa)
      guard_lvl = 2'h0;
    else if (chk_byte[0] == 8'hcc)
      guard_lvl = 2'h2;
    else
      guard_lvl = 2'h1;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] pend;
    pend = flag_nxt & mask_nxt;
    irq_nxt = (fault_ie_nxt & (pend[0] | pend[1])) |
      (done_ie_nxt & pend[2]);
    // option programming gate
    // a reload in flight blocks the grant too
    go_nxt = opt_pgm_req & wr_allow_r & (st_r == FOC_IDLE);
    rdata_nxt = 32'h00000000;
    if (rd) begin
      unique case (addr)
        `FOC_OFS_STATUS, `FOC_OFS_IRQ_STAT: begin
          rdata_nxt[`FOC_BIT_PGM_FAULT] = flag_r[0];
          rdata_nxt[`FOC_BIT_PROT_FAULT] = flag_r[1];
          rdata_nxt[`FOC_BIT_DONE] = flag_r[2];
        end
        `FOC_OFS_CTRL: begin
          rdata_nxt[`FOC_BIT_WR_ALLOW] = wr_allow_r;
          rdata_nxt[`FOC_BIT_FAULT_IE] = fault_ie_r;
          rdata_nxt[`FOC_BIT_DONE_IE] = done_ie_r;
        end
        `FOC_OFS_IRQ_MASK: rdata_nxt[2:0] = mask_r;
        `FOC_OFS_OPT: rdata_nxt = opt_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= FOC_LOAD;
      rcnt_r <= 4'h0;
      opt_r <= 32'h00000000;
      taddr_r <= `FOC_RST_ADDR;
      wr_allow_r <= 1'b0;
      fault_ie_r <= 1'b0;
      done_ie_r <= 1'b0;
      flag_r <= 3'h0;
      mask_r <= `FOC_RST_MASK;
      rdata <= 32'h00000000;
      irq <= 1'b0;
      opt_pgm_go <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rcnt_r <= rcnt_nxt;
      opt_r <= opt_nxt;
      taddr_r <= taddr_nxt;
      wr_allow_r <= wr_allow_nxt;
      fault_ie_r <= fault_ie_nxt;
      done_ie_r <= done_ie_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      rdata <= rdata_nxt;
      irq <= irq_nxt;
      opt_pgm_go <= go_nxt;
      sys_reset_req <= sysrst_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_reload_wr;
    wr && addr == `FOC_OFS_CTRL && wdata[`FOC_BIT_RELOAD]
      && st_r == FOC_IDLE;
  endsequence
  // eight cycles of system reset, then released
  sequence s_reset_pulse;
    sys_reset_req [*8] ##1 !sys_reset_req;
  endsequence
  AST_PGM_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    opt_pgm_go |-> $past(wr_allow_r) && $past(opt_pgm_req))
    else $error("option program passed while not allowed");
  AST_FAULT_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_ie_r && (flag_r[0] & mask_r[0])) |-> irq)
    else $error("fault interrupt missing");
  AST_DONE_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    (!done_ie_r && !fault_ie_r) |-> !irq)
    else $error("interrupt while disabled");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    s_reload_wr |-> ##3 s_reset_pulse)
    else $error("reload reset pulse wrong");
  AST_ADDR_TRACK: assert property (@(posedge clk) disable iff (!rst_n)
    op_busy |=> taddr_r == $past(op_addr))
    else $error("target address not tracked");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    evt.done |=> flag_r[2])
    else $error("done flag lost");
  AST_PROT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    evt.prot_fault |=> flag_r[1])
    else $error("protect fault flag lost");
  AST_OPT_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == FOC_LOAD && chk_bad[3]) |=>
      opt_r[31:24] == 8'hff && opt_r[0])
    else $error("mismatch not forced to erased");

  // ------------------------------------------------------------
  // interrupt checks
  // ------------------------------------------------------------
  // a protect fault alone must also reach the request
  AST_PROT_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_ie_r && flag_r[1] && mask_r[1]) |-> irq)
    else $error("protect fault interrupt missing");
  AST_PGM_SET: assert property (@(posedge clk) disable iff (!rst_n)
    evt.pgm_fault |=> flag_r[0])
    else $error("program fault flag lost");
  AST_DONE_IRQ_ON: assert property (@(posedge clk) disable iff (!rst_n)
    (done_ie_r && flag_r[2] && mask_r[2]) |-> irq)
    else $error("done interrupt missing");
  AST_FAULT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (!fault_ie_r && !(done_ie_r && flag_r[2] && mask_r[2])) |-> !irq)
    else $error("fault interrupt while disabled");
  AST_DONE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (!done_ie_r && !(fault_ie_r && (flag_r[1:0] & mask_r[1:0]) != 2'h0))
      |-> !irq)
    else $error("done interrupt while disabled");
  // with every source masked nothing may leak through
  AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
    (mask_r == 3'h0) |-> !irq)
    else $error("interrupt while all sources masked");
  AST_IRQ_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
    irq |-> (flag_r & mask_r) != 3'h0)
    else $error("interrupt without an unmasked flag");

  // ------------------------------------------------------------
  // address checks
  // ------------------------------------------------------------
  // a software write lands only while no operation owns the register
  AST_ADDR_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == `FOC_OFS_ADDR && !op_busy) |=> taddr_r == $past(wdata))
    else $error("target address write lost");
  // the last used address stays once the operation is over
  AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (!op_busy && !(wr && addr == `FOC_OFS_ADDR)) |=> $stable(taddr_r))
    else $error("target address changed while idle");

  // ------------------------------------------------------------
  // reload and option checks
  // ------------------------------------------------------------
  AST_GO_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r != FOC_IDLE) |=> !opt_pgm_go)
    else $error("option program passed during reload");
  // control bits come back cleared when the reset pulse ends
  AST_RESET_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sys_reset_req) |-> !wr_allow_r && !fault_ie_r && !done_ie_r)
    else $error("control bits survive reload");
  AST_OPT_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == FOC_LOAD) |=> opt_r[0] == $past(|chk_bad))
    else $error("option fault bit not loaded");
  AST_OPT_USER: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == FOC_LOAD) |=> opt_r[10:8] == $past(chk_byte[1][2:0]))
    else $error("watchdog or low power bits not loaded");
  AST_OPT_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == FOC_LOAD) |=>
      opt_r[31:16] == {$past(chk_byte[3]), $past(chk_byte[2])})
    else $error("user data bytes not loaded");
endmodule
`default_nettype wire

// [tb/test_flash_option_ctrl_status.sv]
// testbench of the flash option control / status block
// assumes foc_top with a one-cycle register port and read data a cycle later
`timescale 1ns/1ps
`default_nettype none
`include "foc_map.svh"
module test_flash_option_ctrl_status
  import foc_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, op_addr = 32'h0, rdata;
  foc_evt_t evt = 3'h0;
  logic op_busy = 1'b0, opt_pgm_req = 1'b0, opt_pgm_go, sys_reset_req, irq;
  // good pairs: guard level 0, user byte 0x35, data 0x12 and 0x34
  foc_opt_pair_t opt_guard = 16'h55aa, opt_user = 16'hca35;
  foc_opt_pair_t opt_user_byte_low = 16'hed12, opt_user_byte_high = 16'hcb34;
  int failures = 0, checks = 0, n;

  foc_top foc_top_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .evt(evt),
    .op_busy(op_busy), .op_addr(op_addr), .opt_pgm_req(opt_pgm_req),
    .opt_pgm_go(opt_pgm_go), .opt_guard(opt_guard), .opt_user(opt_user),
    .opt_user_byte_low(opt_user_byte_low), .opt_user_byte_high(opt_user_byte_high),
    .sys_reset_req(sys_reset_req), .irq(irq));

  initial begin
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // one event pulse, then irq has had time to register
  task automatic pulse(input foc_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic settle_irq(input logic exp);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, {31'h0, exp});
  endtask

  // counts the cycles of the system reset pulse into n
  task automatic wait_pulse();
    for (int i = 0; i < 20 && sys_reset_req !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    n = 0;
    while (sys_reset_req === 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog, generous against a run of about 115 cycles
  // ----------------------------------------------------------------
  initial begin
    #20000;
    failures++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_pulse();
    check(n, 32'h8);
    rd_reg(`FOC_OFS_OPT, 32'h34123500);
    rd_reg(`FOC_OFS_CTRL, 32'h0);
    wr_reg(`FOC_OFS_CTRL, 32'h00001600);
    rd_reg(`FOC_OFS_CTRL, 32'h00001600);
    @(posedge clk);
    opt_pgm_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check({31'h0, opt_pgm_go}, 32'h1);
    wr_reg(`FOC_OFS_CTRL, 32'h00000400);
    repeat (2) @(posedge clk);
    #1 check({31'h0, opt_pgm_go}, 32'h0);
    pulse(3'b001);
    check({31'h0, irq}, 32'h0);
    rd_reg(`FOC_OFS_STATUS, 32'h00000020);
    wr_reg(`FOC_OFS_STATUS, 32'h00000020);
    pulse(3'b100);
    check({31'h0, irq}, 32'h1);
    wr_reg(`FOC_OFS_IRQ_MASK, 32'h0);
    settle_irq(1'b0);
    wr_reg(`FOC_OFS_IRQ_MASK, 32'h7);
    settle_irq(1'b1);
    wr_reg(`FOC_OFS_STATUS, 32'h00000004);
    settle_irq(1'b0);
    pulse(3'b010);
    check({31'h0, irq}, 32'h1);
    rd_reg(`FOC_OFS_STATUS, 32'h00000010);
    wr_reg(`FOC_OFS_STATUS, 32'h00000010);
    wr_reg(`FOC_OFS_CTRL, 32'h00001000);
    pulse(3'b001);
    check({31'h0, irq}, 32'h1);
    wr_reg(`FOC_OFS_CTRL, 32'h0);
    settle_irq(1'b0);
    wr_reg(`FOC_OFS_STATUS, 32'h00000020);
    wr_reg(`FOC_OFS_ADDR, 32'h08000400);
    @(posedge clk);
    op_busy <= 1'b1;
    op_addr <= 32'h08000800;
    @(posedge clk);
    op_busy <= 1'b0;
    rd_reg(`FOC_OFS_ADDR, 32'h0);
    rd_reg(8'h30, 32'h0);
    // guard level 2 and broken data pairs, then forced reload
    @(posedge clk);
    opt_guard <= 16'h33cc;
    opt_user_byte_low <= 16'h0012;
    opt_user_byte_high <= 16'h0034;
    wr_reg(`FOC_OFS_CTRL, 32'h00002000);
    wait_pulse();
    check(n, 32'h8);
    rd_reg(`FOC_OFS_OPT, 32'hffff3505);
    rd_reg(`FOC_OFS_CTRL, 32'h0);
    // guard level 1 with good data pairs, reloaded again
    @(posedge clk);
    opt_guard <= 16'h00ff;
    opt_user_byte_low <= 16'hed12;
    opt_user_byte_high <= 16'hcb34;
    wr_reg(`FOC_OFS_CTRL, 32'h00002000);
    wait_pulse();
    check(n, 32'h8);
    rd_reg(`FOC_OFS_OPT, 32'h34123502);
    stop_test();
  end
endmodule
`default_nettype wire
